/* rtl/dgc_pkg.sv */
package dgc_pkg;
  // ==========================================
  // Register map
  localparam logic [7:0]  ADDR_CFG0  = 8'h00;
  localparam logic [7:0]  ADDR_CFG1  = 8'h04;
  localparam logic [7:0]  ADDR_INIT  = 8'h08;
  localparam logic [7:0]  ADDR_STAT  = 8'h0C;
  localparam logic [31:0] CFG0_RST   = 32'hA8003E3F;
  localparam logic [31:0] CFG0_WMASK = 32'hFC07FFFF;
  localparam logic [31:0] CFG1_RST   = 32'h0100C403;
  localparam logic [31:0] CFG1_WMASK = 32'hFFFFFFC7;
  localparam logic [31:0] INIT_WMASK = 32'h00000201;
  // ==========================================
  // Field positions
  localparam int CLOCK_PAIR_DRIVE_SELECT_LSB = 26;
  localparam int TSEL_LSB = 14;
  localparam int OWDL_LSB = 12;
  localparam int ODIV_LSB = 9;
  localparam int OSCR_BIT = 8;
  localparam int LTRG_BIT = 7;
  localparam int LTMD_BIT = 6;
  localparam int LBAC_BIT = 31;
  localparam int LBGM_LSB = 29;
  localparam int LBSS_BIT = 28;
  localparam int LBPT_BIT = 27;
  localparam int INHB_BIT = 26;
  localparam int FRST_BIT = 25;
  localparam int ZDIV_LSB = 23;
  localparam int DLIM_LSB = 15;
  localparam int IAVG_LSB = 13;
  localparam int SMDP_LSB = 11;
  localparam int SMEN_BIT = 10;
  localparam int MTRK_BIT = 9;
  localparam int IOVM_LSB = 7;
  localparam int LSEL_BIT = 6;
  localparam int LSTP_BIT = 2;
  localparam int MLVL_BIT = 1;
  localparam int PDWN_BIT = 0;
  localparam int LVL_BIT  = 9;
  localparam int TRG_BIT  = 0;
  // ==========================================
  // Carrier types
  typedef struct packed {
    logic [5:0] clock_pair_drive;
    logic [4:0] test_output_select;
    logic [1:0] leveling_line_sel;
    logic [2:0] oscillator_divide;
    logic       oscillator_run;
    logic       line_test_mode;
    logic [5:0] drift_comp_en;
  } dgc_cfg0_t;
  typedef struct packed {
    logic       loopback_active;
    logic [1:0] loopback_gate_mode;
    logic       loopback_strobe_shift;
    logic       loopback_point_select;
    logic       drift_calc_inhibit;
    logic       macro_fast_reset_n;
    logic [1:0] impedance_clock_divide;
    logic [7:0] drift_limit;
    logic [1:0] initial_average_depth;
    logic [1:0] smoothing_depth;
    logic       smoothing_enable;
    logic       master_line_tracking_enable;
    logic [1:0] io_voltage_mode;
    logic       leveling_select_encoding;
    logic       leveling_step_size;
    logic       manual_leveling_mode;
    logic       unused_lane_power_down;
  } dgc_cfg1_t;
endpackage

/* rtl/dgc_top.sv */
// Added by the designer: the AHB-Lite interface to the registers and the register offsets.
`timescale 1ns/1ps
module dgc_top #(
  parameter int DRIFT_W = 8
) (
  // Clock and reset
  input  wire logic               REF_CLK_I,
  input  wire logic               RST_I,
  // AHB-Lite slave
  input  wire logic               HSEL_I,
  input  wire logic [31:0]        HADDR_I,
  input  wire logic [1:0]         HTRANS_I,
  input  wire logic               HWRITE_I,
  input  wire logic [2:0]         HSIZE_I,
  input  wire logic [31:0]        HWDATA_I,
  input  wire logic               HREADY_I,
  output      logic [31:0]        HRDATA_O,
  output      logic               HREADYOUT_O,
  output      logic               HRESP_O,
  // PHY status inputs
  input  wire logic               LINE_TEST_DONE_I,
  input  wire logic               LEVELING_DONE_I,
  input  wire logic               DRIFT_STOPPED_I,
  input  wire logic [DRIFT_W-1:0] DRIFT_STEPS_I,
  // PHY control outputs
  output      dgc_pkg::dgc_cfg0_t CFG0_O,
  output      dgc_pkg::dgc_cfg1_t CFG1_O,
  output      logic               LINE_TEST_START_O,
  output      logic               LEVELING_STROBE_O,
  output      logic               MACRO_RESET_O,
  output      logic               FORCE_STROBE_DELAY_ZERO_O,
  output      logic               DDR_LINE_ACTIVE_O,
  output      logic               SDR_LINE_ACTIVE_O,
  output      logic               DRIFT_FLAG_O
);
  import dgc_pkg::*;

  // ==========================================
  // Bus address phase capture
  logic [31:0] cfg0_r;
  logic [31:0] cfg1_r;
  logic        lvl_r;
  logic        trig_prev_r;
  logic        wr_r;
  logic        rd_r;
  logic [7:0]  adr_r;
  logic [31:0] rdata_nxt;
  logic [31:0] rdata_r;
  logic        drift_r;

  wire take = HSEL_I && HREADY_I && HTRANS_I[1];
  wire ok_size = (HSIZE_I == 3'h2);

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      wr_r  <= 1'b0;
      rd_r  <= 1'b0;
      adr_r <= 8'h00;
    end
    else
    begin
      wr_r  <= take && HWRITE_I && ok_size;
      rd_r  <= take && !HWRITE_I;
      adr_r <= HADDR_I[7:0];
    end
  end

  // ==========================================
  // Register write decode
  wire wr_cfg0 = wr_r && (adr_r == ADDR_CFG0);
  wire wr_cfg1 = wr_r && (adr_r == ADDR_CFG1);
  wire wr_init = wr_r && (adr_r == ADDR_INIT);
  wire lvl_set = wr_init && HWDATA_I[LVL_BIT] && HWDATA_I[TRG_BIT];

  // Reserved positions keep their reset value on write
  wire [31:0] cfg0_wv = (HWDATA_I & CFG0_WMASK) | (CFG0_RST & ~CFG0_WMASK);
  wire [31:0] cfg1_wv = (HWDATA_I & CFG1_WMASK) | (CFG1_RST & ~CFG1_WMASK);

  // Values held after this edge, so a read right after a write sees them
  wire [31:0] cfg0_nxt = wr_cfg0 ? cfg0_wv : cfg0_r;
  wire [31:0] cfg1_nxt = wr_cfg1 ? cfg1_wv : cfg1_r;
  wire        lvl_nxt  = lvl_set || (lvl_r && !LEVELING_DONE_I);

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      cfg0_r <= CFG0_RST;
      cfg1_r <= CFG1_RST;
    end
    else
    begin
      if (wr_cfg0)
        cfg0_r <= cfg0_wv;
      if (wr_cfg1)
        cfg1_r <= cfg1_wv;
    end
  end

  // Leveling bit: done clears, a new request in the same cycle wins
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
    begin
      lvl_r       <= 1'b0;
      trig_prev_r <= 1'b0;
    end
    else
    begin
      lvl_r       <= lvl_set || (lvl_r && !LEVELING_DONE_I);
      trig_prev_r <= cfg0_r[LTRG_BIT];
    end
  end

  // ==========================================
  // Read data
  wire [31:0] stat_w = {1'b0, DRIFT_STOPPED_I, 28'h0000000,
                        drift_r, LINE_TEST_DONE_I};
  // Looked up in the address phase, registered for the data phase
  wire       rd_take = take && !HWRITE_I;
  wire [7:0] rd_adr  = HADDR_I[7:0];
  always_comb
  begin
    rdata_nxt = 32'h00000000;
    unique case (rd_adr)
      ADDR_CFG0: rdata_nxt = cfg0_nxt & CFG0_WMASK;
      ADDR_CFG1: rdata_nxt = cfg1_nxt & CFG1_WMASK;
      ADDR_INIT: rdata_nxt = {22'h000000, lvl_nxt, 9'h000};
      ADDR_STAT: rdata_nxt = stat_w;
      default:   rdata_nxt = 32'h00000000;
    endcase
  end

  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      rdata_r <= 32'h00000000;
    else
      rdata_r <= rd_take ? rdata_nxt : 32'h00000000;
  end
  assign HRDATA_O    = rdata_r;
  assign HREADYOUT_O = 1'b1;
  assign HRESP_O     = 1'b0;

  // ==========================================
  // Configuration outputs
  assign CFG0_O = '{
    clock_pair_drive:   cfg0_r[CLOCK_PAIR_DRIVE_SELECT_LSB +: 6],
    test_output_select: cfg0_r[TSEL_LSB +: 5],
    leveling_line_sel:  cfg0_r[OWDL_LSB +: 2],
    oscillator_divide:  cfg0_r[ODIV_LSB +: 3],
    oscillator_run:     cfg0_r[OSCR_BIT],
    line_test_mode:     cfg0_r[LTMD_BIT],
    drift_comp_en:      cfg0_r[5:0]
  };
  assign CFG1_O = '{
    loopback_active:             cfg1_r[LBAC_BIT],
    loopback_gate_mode:          cfg1_r[LBGM_LSB +: 2],
    loopback_strobe_shift:       cfg1_r[LBSS_BIT],
    loopback_point_select:       cfg1_r[LBPT_BIT],
    drift_calc_inhibit:          cfg1_r[INHB_BIT],
    macro_fast_reset_n:          cfg1_r[FRST_BIT],
    impedance_clock_divide:      cfg1_r[ZDIV_LSB +: 2],
    drift_limit:                 cfg1_r[DLIM_LSB +: 8],
    initial_average_depth:       cfg1_r[IAVG_LSB +: 2],
    smoothing_depth:             cfg1_r[SMDP_LSB +: 2],
    smoothing_enable:            cfg1_r[SMEN_BIT],
    master_line_tracking_enable: cfg1_r[MTRK_BIT],
    io_voltage_mode:             cfg1_r[IOVM_LSB +: 2],
    leveling_select_encoding:    cfg1_r[LSEL_BIT],
    leveling_step_size:          cfg1_r[LSTP_BIT],
    manual_leveling_mode:        cfg1_r[MLVL_BIT],
    unused_lane_power_down:      cfg1_r[PDWN_BIT]
  };

  // Measurement launched on rising edge of the trigger bit only
  assign LINE_TEST_START_O = cfg0_r[LTRG_BIT] && !trig_prev_r;
  // One strobe per software trigger in manual leveling
  assign LEVELING_STROBE_O = lvl_set && cfg1_r[MLVL_BIT];
  assign MACRO_RESET_O     = !cfg1_r[FRST_BIT];
  assign FORCE_STROBE_DELAY_ZERO_O =
    cfg1_r[LBAC_BIT] && !cfg1_r[LBSS_BIT];
  assign DDR_LINE_ACTIVE_O = cfg0_r[OWDL_LSB];
  assign SDR_LINE_ACTIVE_O = cfg0_r[OWDL_LSB + 1];

  // ==========================================
  // Drift flag
  wire [7:0] lim = cfg1_r[DLIM_LSB +: 8];
  always_ff @(posedge REF_CLK_I)
  begin
    if (RST_I)
      drift_r <= 1'b0;
    else
      drift_r <= (lim != 8'h00) &&
                 (8'(DRIFT_STEPS_I) >= lim);
  end
  assign DRIFT_FLAG_O = drift_r;

  // ==========================================
  // Assertions
  property p_zero_lim;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (lim == 8'h00) |=> !drift_r;
  endproperty
  a_zero_lim: assert property (p_zero_lim)
    else $error("drift flag with zero limit");

  property p_trig_once;
    @(posedge REF_CLK_I) disable iff (RST_I)
    LINE_TEST_START_O |=> !LINE_TEST_START_O;
  endproperty
  a_trig_once: assert property (p_trig_once)
    else $error("line test start repeated");

  property p_trig_hold;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (cfg0_r[LTRG_BIT] && !wr_cfg0) |=> cfg0_r[LTRG_BIT];
  endproperty
  a_trig_hold: assert property (p_trig_hold)
    else $error("trigger bit cleared by hardware");

  property p_macro;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (wr_cfg1 && !HWDATA_I[FRST_BIT]) |=> MACRO_RESET_O;
  endproperty
  a_macro: assert property (p_macro)
    else $error("macro reset not held");

  property p_resv;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (rd_r && adr_r == ADDR_CFG0) |-> (HRDATA_O[25:19] == 7'h00);
  endproperty
  a_resv: assert property (p_resv)
    else $error("reserved bits nonzero");

  property p_resv1;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (rd_r && adr_r == ADDR_CFG1) |-> (HRDATA_O[5:3] == 3'h0);
  endproperty
  a_resv1: assert property (p_resv1)
    else $error("reserved bits nonzero");

  property p_lvl;
    @(posedge REF_CLK_I) disable iff (RST_I)
    (lvl_r && LEVELING_DONE_I && !lvl_set) |=> !lvl_r;
  endproperty
  a_lvl: assert property (p_lvl)
    else $error("leveling bit not self cleared");

  property p_strb;
    @(posedge REF_CLK_I) disable iff (RST_I)
    LEVELING_STROBE_O |=> (lvl_r && !LEVELING_STROBE_O);
  endproperty
  a_strb: assert property (p_strb)
    else $error("leveling strobe not single");

  property p_shift;
    @(posedge REF_CLK_I) disable iff (RST_I)
    FORCE_STROBE_DELAY_ZERO_O |-> CFG1_O.loopback_active;
  endproperty
  a_shift: assert property (p_shift)
    else $error("strobe forced outside loopback");

  property p_ckdrv;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg0 |=> (CFG0_O.clock_pair_drive == $past(HWDATA_I[CLOCK_PAIR_DRIVE_SELECT_LSB +: 6]));
  endproperty
  a_ckdrv: assert property (p_ckdrv)
    else $error("clock pair drive code not taken");

  property p_tsel;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg0 |=> (CFG0_O.test_output_select == $past(HWDATA_I[TSEL_LSB +: 5]));
  endproperty
  a_tsel: assert property (p_tsel)
    else $error("test output select not taken");

  property p_lines;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg0 |=> ({SDR_LINE_ACTIVE_O, DDR_LINE_ACTIVE_O} ==
                 $past(HWDATA_I[OWDL_LSB +: 2]));
  endproperty
  a_lines: assert property (p_lines)
    else $error("leveling line actives wrong");

  property p_odiv;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg0 |=> (CFG0_O.oscillator_divide == $past(HWDATA_I[ODIV_LSB +: 3]));
  endproperty
  a_odiv: assert property (p_odiv)
    else $error("oscillator divide not taken");

  property p_dcomp;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg0 |=> (CFG0_O.drift_comp_en == $past(HWDATA_I[5:0]));
  endproperty
  a_dcomp: assert property (p_dcomp)
    else $error("drift compensation enables not taken");

  property p_resv0w;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg0 |=> (cfg0_r[25:19] == 7'h00);
  endproperty
  a_resv0w: assert property (p_resv0w)
    else $error("reserved bits stored");

  property p_resv1w;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg1 |=> (cfg1_r[5:3] == 3'h0);
  endproperty
  a_resv1w: assert property (p_resv1w)
    else $error("reserved bits stored");

  property p_gate;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg1 |=> (CFG1_O.loopback_gate_mode == $past(HWDATA_I[LBGM_LSB +: 2]));
  endproperty
  a_gate: assert property (p_gate)
    else $error("loopback gate mode not taken");

  property p_lbpt;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg1 |=> (CFG1_O.loopback_point_select == $past(HWDATA_I[LBPT_BIT]));
  endproperty
  a_lbpt: assert property (p_lbpt)
    else $error("loopback point not taken");

  property p_zdiv;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg1 |=> (CFG1_O.impedance_clock_divide ==
                 $past(HWDATA_I[ZDIV_LSB +: 2]));
  endproperty
  a_zdiv: assert property (p_zdiv)
    else $error("impedance divider not taken");

  property p_lvlsel;
    @(posedge REF_CLK_I) disable iff (RST_I)
    wr_cfg1 |=> ({CFG1_O.leveling_select_encoding, CFG1_O.leveling_step_size}
                 == $past({HWDATA_I[LSEL_BIT], HWDATA_I[LSTP_BIT]}));
  endproperty
  a_lvlsel: assert property (p_lvlsel)
    else $error("leveling encoding or step not taken");

  property p_lvlset;
    @(posedge REF_CLK_I) disable iff (RST_I)
    lvl_set |=> lvl_r;
  endproperty
  a_lvlset: assert property (p_lvlset)
    else $error("leveling bit not set");

  c_trig:  cover property (@(posedge REF_CLK_I) LINE_TEST_START_O);
  c_strb:  cover property (@(posedge REF_CLK_I) LEVELING_STROBE_O);
  c_drift: cover property (@(posedge REF_CLK_I) DRIFT_FLAG_O);
  c_loop:  cover property (@(posedge REF_CLK_I) FORCE_STROBE_DELAY_ZERO_O);
  c_lvl:   cover property (@(posedge REF_CLK_I) lvl_r && LEVELING_DONE_I);
endmodule

/* tb/dgc_phy_model.sv */
`timescale 1ns/1ps
// ==========
// Far-side PHY status responder
module dgc_phy_model (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Requests from the bank
  input  wire logic start_i,
  input  wire logic strobe_i,
  input  wire logic inhibit_i,
  // Status back
  output logic      test_done_o,
  output logic      lvl_done_o,
  output logic      stopped_o
);
  logic [1:0] lvl_dly_r;
  always @(posedge clk_i)
  begin
    if (rst_i)
    begin
      test_done_o <= 1'b0;
      lvl_done_o  <= 1'b0;
      stopped_o   <= 1'b0;
      lvl_dly_r   <= 2'h0;
    end
    else
    begin
      if (start_i)
        test_done_o <= 1'b1;
      lvl_dly_r  <= {lvl_dly_r[0], strobe_i};
      lvl_done_o <= lvl_dly_r[1];
      stopped_o  <= inhibit_i;
    end
  end
endmodule

/* tb/dgc_top_tb_top.sv */
`timescale 1ns/1ps
module dgc_top_tb_top;
  import dgc_pkg::*;
  logic        clk, rst, hsel, hwrite;
  logic [2:0]  hsize;
  logic [1:0]  htrans;
  logic [31:0] haddr, hwdata, rd, base1;
  logic [7:0]  steps;
  wire  [31:0] hrdata;
  wire         hready, hresp, t_start, l_strobe, mrst, fzero;
  wire         ddr_a, sdr_a, dflag, t_done, l_done, stopped;
  wire dgc_cfg0_t cfg0;
  wire dgc_cfg1_t cfg1;
  int          n_errors = 0, checks_done = 0, cycles = 0;
  int          n_start = 0, n_strobe = 0;
  // ==========
  // Clock, design and far side
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  dgc_top uut (.REF_CLK_I(clk), .RST_I(rst), .HSEL_I(hsel),
    .HADDR_I(haddr), .HTRANS_I(htrans), .HWRITE_I(hwrite),
    .HSIZE_I(hsize), .HWDATA_I(hwdata), .HREADY_I(hready),
    .HRDATA_O(hrdata), .HREADYOUT_O(hready), .HRESP_O(hresp),
    .LINE_TEST_DONE_I(t_done), .LEVELING_DONE_I(l_done),
    .DRIFT_STOPPED_I(stopped), .DRIFT_STEPS_I(steps),
    .CFG0_O(cfg0), .CFG1_O(cfg1), .LINE_TEST_START_O(t_start),
    .LEVELING_STROBE_O(l_strobe), .MACRO_RESET_O(mrst),
    .FORCE_STROBE_DELAY_ZERO_O(fzero), .DDR_LINE_ACTIVE_O(ddr_a),
    .SDR_LINE_ACTIVE_O(sdr_a), .DRIFT_FLAG_O(dflag));
  dgc_phy_model phy (.clk_i(clk), .rst_i(rst), .start_i(t_start),
    .strobe_i(l_strobe), .inhibit_i(cfg1.drift_calc_inhibit),
    .test_done_o(t_done), .lvl_done_o(l_done), .stopped_o(stopped));
  // ==========
  // Pulse counters and timeout
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (t_start)
      n_start <= n_start + 1;
    if (l_strobe)
      n_strobe <= n_strobe + 1;
    if (cycles == 3000)
    begin
      n_errors = n_errors + 1;
      $display("CHECK FAILED t=%0t timeout", $time);
      end_of_test();
    end
  end
  // ==========
  // Bus and compare tasks
  task chk(input logic [31:0] got, input logic [31:0] exp, input string m);
    checks_done++;
    if (got !== exp)
    begin
      n_errors++;
      $display("CHECK FAILED t=%0t %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task bus(input logic w, input logic [31:0] a, input logic [31:0] d);
    @(posedge clk);
    haddr  <= a;
    hwrite <= w;
    htrans <= 2'b10;
    hsize  <= 3'h2;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rd = hrdata;
  endtask
  task rd_chk(input logic [31:0] a, input logic [31:0] exp, input string m);
    bus(1'b0, a, 32'h0);
    chk(rd, exp, m);
  endtask
  // ==========
  // Scenarios
  task t_reset;
    rd_chk(ADDR_CFG0, 32'hA8003E3F, "cfg0 reset");
    chk({cfg1.impedance_clock_divide, cfg1.drift_limit,
         cfg1.initial_average_depth, cfg1.smoothing_enable,
         cfg1.master_line_tracking_enable, cfg1.loopback_active},
        {2'h2, 8'h01, 2'h2, 1'b1, 1'b0, 1'b0}, "cfg1 reset");
    rd_chk(ADDR_CFG1, 32'h0100C403, "cfg1 read reset");
    rd_chk(ADDR_STAT, 32'h0, "status idle");
    chk({mrst, sdr_a, ddr_a}, 3'b111, "reset outputs");
  endtask
  task t_mask;
    bus(1'b1, ADDR_CFG0, 32'hFFFFFFFF);
    rd_chk(ADDR_CFG0, 32'hFC07FFFF, "cfg0 reserved");
    bus(1'b1, ADDR_CFG1, 32'hFFFFFFFF);
    rd_chk(ADDR_CFG1, 32'hFFFFFFC7, "cfg1 reserved");
    rd_chk(32'h10, 32'h0, "unmapped read");
  endtask
  task t_line;
    int n0;
    n0 = n_start;
    bus(1'b1, ADDR_CFG0, 32'h0);
    bus(1'b1, ADDR_CFG0, 32'h80);
    bus(1'b1, ADDR_CFG0, 32'h80);
    repeat (3) @(posedge clk);
    chk(n_start - n0, 1, "one start pulse");
    rd_chk(ADDR_CFG0, 32'h80, "trigger kept");
    bus(1'b1, ADDR_CFG0, 32'h0);
    bus(1'b1, ADDR_CFG0, 32'h80);
    repeat (3) @(posedge clk);
    chk(n_start - n0, 2, "relaunch");
    bus(1'b0, ADDR_STAT, 32'h0);
    chk(rd & 32'h1, 1, "test done status");
  endtask
  task t_lines;
    for (int c = 0; c < 4; c++)
    begin
      bus(1'b1, ADDR_CFG0, c << OWDL_LSB);
      @(posedge clk);
      chk({sdr_a, ddr_a}, c, "leveling lines");
    end
  endtask
  task t_fields;
    bus(1'b1, ADDR_CFG0, 32'h00064140);
    @(posedge clk);
    chk({cfg0.clock_pair_drive, cfg0.test_output_select,
         cfg0.oscillator_divide, cfg0.oscillator_run,
         cfg0.line_test_mode, cfg0.drift_comp_en},
        {6'h00, 5'h19, 3'h0, 1'b1, 1'b1, 6'h00},
        "cfg0 fields");
    bus(1'b1, ADDR_CFG1, 32'h4A8018C4);
    @(posedge clk);
    chk({cfg1.loopback_gate_mode, cfg1.loopback_point_select,
         cfg1.impedance_clock_divide, cfg1.smoothing_depth,
         cfg1.io_voltage_mode, cfg1.leveling_select_encoding,
         cfg1.leveling_step_size, mrst},
        {2'h2, 1'b1, 2'h1, 2'h3, 2'h1, 1'b1, 1'b1, 1'b0},
        "cfg1 fields");
    rd_chk(ADDR_CFG1, 32'h4A8018C4, "cfg1 readback");
  endtask
  task t_loop;
    bus(1'b1, ADDR_CFG1, 1 << LBAC_BIT);
    @(posedge clk);
    chk({mrst, fzero}, 2'b11, "shift zero, macros held");
    bus(1'b1, ADDR_CFG1, base1 | (1 << LBAC_BIT) | (1 << LBSS_BIT));
    @(posedge clk);
    chk({mrst, fzero}, 2'b00, "manual shift, released");
  endtask
  task t_drift;
    bus(1'b1, ADDR_CFG1, base1 | (4 << DLIM_LSB));
    steps <= 8'h03;
    repeat (3) @(posedge clk);
    chk(dflag, 1'b0, "below limit");
    steps <= 8'h04;
    repeat (3) @(posedge clk);
    chk(dflag, 1'b1, "at limit");
    bus(1'b1, ADDR_CFG1, base1);
    steps <= 8'hFF;
    repeat (3) @(posedge clk);
    chk(dflag, 1'b0, "limit zero");
    bus(1'b1, ADDR_CFG1, base1 | (1 << INHB_BIT));
    repeat (3) @(posedge clk);
    bus(1'b0, ADDR_STAT, 32'h0);
    chk(rd[30], 1'b1, "drift stopped");
  endtask
  task t_level;
    int n0;
    n0 = n_strobe;
    bus(1'b1, ADDR_CFG1, base1 | (1 << MLVL_BIT));
    bus(1'b1, ADDR_INIT, 32'h201);
    repeat (8) @(posedge clk);
    chk(n_strobe - n0, 1, "one strobe");
    rd_chk(ADDR_INIT, 32'h0, "leveling bit cleared");
    bus(1'b1, ADDR_CFG1, base1);
    bus(1'b1, ADDR_INIT, 32'h201);
    repeat (2) @(posedge clk);
    chk(n_strobe - n0, 1, "no strobe in auto mode");
    rd_chk(ADDR_INIT, 32'h200, "auto leveling pending");
  endtask
  task end_of_test;
    $display("errors %0d checks %0d", n_errors, checks_done);
    if (n_errors == 0 && checks_done > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  // ==========
  // Main sequence
  initial
  begin
    rst    = 1'b1;
    hsel   = 1'b0;
    haddr  = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize  = 3'h2;
    hwdata = 32'h0;
    steps  = 8'h00;
    base1  = (1 << FRST_BIT) | (1 << IOVM_LSB);
    repeat (12) @(posedge clk);
    rst  <= 1'b0;
    hsel <= 1'b1;
    t_reset();
    t_mask();
    t_line();
    t_lines();
    t_fields();
    t_loop();
    t_drift();
    t_level();
    end_of_test();
  end
endmodule
